// ---- iocell_top.sv ----
module iocell_top
  import iocell_pkg::*;
#(
  parameter logic [1:0] CELL_EDGE = EDGE_LEFT,
  parameter logic       PROG_PIN  = 1'b0
)(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pad_in,
  input  wire logic        sys_clk_in,
  input  wire logic        strobe_read_clk_shifted,
  input  wire logic        strobe_write_clk_shifted,
  input  wire logic        ddr_capture_polarity,
  input  wire logic        por_released,
  input  wire logic        cell_clk_en,
  input  wire logic        local_sr,
  input  wire logic [4:0]  dynamic_delay_sel,
  input  wire logic        core_out_first,
  input  wire logic        core_out_second,
  input  wire logic        core_tristate_ctl,
  output logic             bypass_comb_in,
  output logic             bypass_clock_in,
  output logic             in_rise_sample,
  output logic             in_fall_or_sdr_sample,
  output logic             pad_out,
  output logic             pad_output_enable,
  output logic             pad_pull_up,
  output logic             pad_pull_down
);

  // Pin synchronisers: stage one feeds stage two only
  logic [5:0]  pin_s1_ff;
  logic [5:0]  pin_s2_ff;
  logic [5:0]  pin_raw;
  logic        sclk_d_ff;
  logic        rstb_d_ff;

  // Configuration and bus
  logic [31:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        configured_ff;

  // Cell storage elements
  logic        in_sdr_ff;
  logic        in_rise_ff;
  logic        in_fall_ff;
  logic        out_first_ff;
  logic        out_second_pre_ff;
  logic        out_second_ff;
  logic        ts_ff;
  logic        pad_out_ff;
  logic        pad_oe_ff;
  logic        pull_up_ff;
  logic        pull_down_ff;
  logic        byp_comb_ff;
  logic        byp_clk_ff;
  logic        in_first_out_ff;
  logic        in_second_out_ff;

  // Synchronised pin levels
  wire         pad_s      = pin_s2_ff[0];
  wire         sclk_s     = pin_s2_ff[1];
  wire         rstb_s     = pin_s2_ff[2];
  wire         wstb_s     = pin_s2_ff[3];
  wire         pol_s      = pin_s2_ff[4];
  wire         por_s      = pin_s2_ff[5];

  assign pin_raw = {por_released, ddr_capture_polarity, strobe_write_clk_shifted,
                    strobe_read_clk_shifted, sys_clk_in, pad_in};

  // Configuration fields
  wire         is_right   = (CELL_EDGE == EDGE_RIGHT);
  wire         is_bottom  = (CELL_EDGE == EDGE_BOTTOM);
  wire         cfg_bypass = ctrl_ff[CTRL_BYPASS_BIT];
  wire         cfg_fixdly = ctrl_ff[CTRL_FIXDLY_BIT];
  wire         cfg_dyndly = ctrl_ff[CTRL_DYNDLY_BIT] && is_bottom;
  wire         cfg_in_ddr = ctrl_ff[CTRL_IN_DDR_BIT];
  wire         cfg_in_mem = ctrl_ff[CTRL_IN_MEM_BIT] && is_right && cfg_in_ddr;
  wire [1:0]   cfg_omode  = ctrl_ff[CTRL_OMODE_MSB:CTRL_OMODE_LSB];
  // Memory mode falls back to generic DDR off the right edge
  wire [1:0]   eff_omode  = (cfg_omode == OMODE_DDR_MEMORY && !is_right) ? OMODE_DDR_GENERIC
                          : cfg_omode;

  // System clock and read strobe edges that clock the cell registers
  wire         sclk_rise  = sclk_s && !sclk_d_ff;
  wire         sclk_fall  = !sclk_s && sclk_d_ff;
  wire         rstb_rise  = rstb_s && !rstb_d_ff;
  wire         rstb_fall  = !rstb_s && rstb_d_ff;

  // Input capture edges: shifted read strobe with polarity in memory mode
  wire         cap_rise   = cfg_in_mem ? (pol_s ? rstb_fall : rstb_rise) : sclk_rise;
  wire         cap_fall   = cfg_in_mem ? (pol_s ? rstb_rise : rstb_fall) : sclk_fall;

  // Delayed pad input
  logic        pad_dly;

  iocell_delay_line u_delay (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .din      (pad_s),
    .fixed_en (cfg_fixdly),
    .dyn_en   (cfg_dyndly),
    .dyn_sel  (dynamic_delay_sel),
    .dout     (pad_dly)
  );

  // Register enables: clock enable gates the capture, output and tristate registers
  wire         hold       = !cell_clk_en;
  wire         sr_now     = local_sr;

  // Input path next values
  wire         nxt_in_sdr  = (sclk_rise && !hold) ? pad_dly : in_sdr_ff;
  wire         nxt_in_rise = (cap_rise && !hold) ? pad_dly : in_rise_ff;
  wire         nxt_in_fall = (cap_fall && !hold) ? pad_dly : in_fall_ff;
  wire         nxt_in_first  = cfg_in_ddr ? in_rise_ff : DATA_SR_VALUE;
  wire         nxt_in_second = cfg_in_ddr ? in_fall_ff : in_sdr_ff;

  // Output path next values
  wire         is_latch    = (eff_omode == OMODE_SDR_LATCH);
  wire         is_ddr_out  = (eff_omode == OMODE_DDR_GENERIC) || (eff_omode == OMODE_DDR_MEMORY);
  wire         first_load  = is_latch ? sclk_s : sclk_rise;
  wire         nxt_out_first = (first_load && !hold) ? core_out_first : out_first_ff;
  wire         nxt_out_spre  = (sclk_rise && !hold) ? core_out_second : out_second_pre_ff;
  wire         nxt_out_sec   = (sclk_fall && !hold) ? out_second_pre_ff : out_second_ff;
  wire         nxt_ts        = (sclk_rise && !hold) ? core_tristate_ctl : ts_ff;

  // Pad data mux: system clock level, or write strobe in memory mode
  // Write strobe selects by level, so it keeps no edge history
  wire         mux_sel    = (eff_omode == OMODE_DDR_MEMORY) ? wstb_s : sclk_s;
  wire         ddr_value  = mux_sel ? out_first_ff : out_second_ff;
  wire         nxt_pad_out = !configured_ff ? 1'b0 : (is_ddr_out ? ddr_value : out_first_ff);

  // Blank state until released and configured
  wire         nxt_configured = por_s && ctrl_ff[CTRL_CFG_DONE_BIT];
  wire         nxt_pad_oe = configured_ff && !ts_ff;
  wire         nxt_pull_up   = !configured_ff && PROG_PIN;
  wire         nxt_pull_down = !configured_ff && !PROG_PIN;

  // Bypass taps the undelayed pad level
  wire         nxt_byp    = configured_ff && cfg_bypass && pad_s;

  // APB decode
  wire         bus_setup  = psel && !penable;
  wire         bus_write  = psel && penable && pready_ff && pwrite;
  wire         hit_ctrl   = (paddr == IOCELL_CTRL_ADDR);
  wire         hit_status = (paddr == IOCELL_STATUS_ADDR);
  wire         addr_ok    = hit_ctrl || hit_status;
  wire [31:0]  status_word = IOCELL_RDATA_ZERO
                           | (32'(configured_ff) << STAT_CONFIGURED_BIT)
                           | (32'(por_s) << STAT_POR_BIT)
                           | (32'(pad_s) << STAT_PAD_IN_BIT)
                           | (32'(in_first_out_ff) << STAT_RISE_BIT)
                           | (32'(in_second_out_ff) << STAT_FALL_BIT)
                           | (32'(pad_out_ff) << STAT_PAD_OUT_BIT)
                           | (32'(pad_oe_ff) << STAT_OE_BIT);
  wire [31:0]  rd_word    = (pwrite || !addr_ok) ? IOCELL_RDATA_ZERO
                          : (hit_ctrl ? ctrl_ff : status_word);
  wire [31:0]  nxt_ctrl   = (bus_write && hit_ctrl) ? (pwdata & CTRL_WRITE_MASK) : ctrl_ff;

  // Top-level outputs
  assign prdata                = prdata_ff;
  assign pready                = pready_ff;
  assign pslverr               = pslverr_ff;
  assign bypass_comb_in        = byp_comb_ff;
  assign bypass_clock_in       = byp_clk_ff;
  assign in_rise_sample        = in_first_out_ff;
  assign in_fall_or_sdr_sample = in_second_out_ff;
  assign pad_out               = pad_out_ff;
  assign pad_output_enable     = pad_oe_ff;
  assign pad_pull_up           = pull_up_ff;
  assign pad_pull_down         = pull_down_ff;

  // Pin synchronisers and edge history
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      sclk_d_ff <= 1'b0;
      rstb_d_ff <= 1'b0;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      sclk_d_ff <= sclk_s;
      rstb_d_ff <= rstb_s;
    end
  end

  // Control register, written in the access cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ff <= IOCELL_CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // APB slave: no wait states, answer in first access cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata_ff  <= IOCELL_RDATA_ZERO;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= bus_setup;
      pslverr_ff <= bus_setup && !addr_ok;
      if (bus_setup) begin
        prdata_ff <= rd_word;
      end
    end
  end

  // Input capture registers
  // Edges come from the synchronised clock and read strobe, so no second clock domain
  always_ff @(posedge ref_clk) begin
    if (reset || sr_now) begin
      in_sdr_ff  <= DATA_SR_VALUE;
      in_rise_ff <= DATA_SR_VALUE;
      in_fall_ff <= DATA_SR_VALUE;
    end else begin
      in_sdr_ff  <= nxt_in_sdr;
      in_rise_ff <= nxt_in_rise;
      in_fall_ff <= nxt_in_fall;
    end
  end

  // Output and tristate registers
  // Set/reset parks the tristate register high, releasing the pad
  always_ff @(posedge ref_clk) begin
    if (reset || sr_now) begin
      out_first_ff      <= DATA_SR_VALUE;
      out_second_pre_ff <= DATA_SR_VALUE;
      out_second_ff     <= DATA_SR_VALUE;
      ts_ff             <= TS_SR_VALUE;
    end else begin
      out_first_ff      <= nxt_out_first;
      out_second_pre_ff <= nxt_out_spre;
      out_second_ff     <= nxt_out_sec;
      ts_ff             <= nxt_ts;
    end
  end

  // Configuration state and pad-side outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      configured_ff    <= 1'b0;
      pad_out_ff       <= 1'b0;
      pad_oe_ff        <= 1'b0;
      pull_up_ff       <= PROG_PIN;
      pull_down_ff     <= !PROG_PIN;
    end else begin
      configured_ff    <= nxt_configured;
      pad_out_ff       <= nxt_pad_out;
      pad_oe_ff        <= nxt_pad_oe;
      pull_up_ff       <= nxt_pull_up;
      pull_down_ff     <= nxt_pull_down;
    end
  end

  // Core-side sample and bypass outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      byp_comb_ff      <= 1'b0;
      byp_clk_ff       <= 1'b0;
      in_first_out_ff  <= 1'b0;
      in_second_out_ff <= 1'b0;
    end else begin
      byp_comb_ff      <= nxt_byp;
      byp_clk_ff       <= nxt_byp;
      in_first_out_ff  <= configured_ff && nxt_in_first;
      in_second_out_ff <= configured_ff && nxt_in_second;
    end
  end

endmodule : iocell_top

// ---- iocell_pkg.sv ----
package iocell_pkg;

  // Register map, byte addresses on the APB side
  localparam logic [7:0]  IOCELL_CTRL_ADDR     = 8'h00;
  localparam logic [7:0]  IOCELL_STATUS_ADDR   = 8'h04;
  localparam logic [31:0] IOCELL_CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] IOCELL_RDATA_ZERO    = 32'h0000_0000;

  // Control register fields
  localparam int          CTRL_BYPASS_BIT      = 0;
  localparam int          CTRL_FIXDLY_BIT      = 1;
  localparam int          CTRL_DYNDLY_BIT      = 2;
  localparam int          CTRL_IN_DDR_BIT      = 3;
  localparam int          CTRL_IN_MEM_BIT      = 4;
  localparam int          CTRL_OMODE_LSB       = 5;
  localparam int          CTRL_OMODE_MSB       = 6;
  localparam int          CTRL_CFG_DONE_BIT    = 8;
  localparam logic [31:0] CTRL_WRITE_MASK      = 32'h0000_017F;

  // Status register fields
  localparam int          STAT_CONFIGURED_BIT  = 0;
  localparam int          STAT_POR_BIT         = 1;
  localparam int          STAT_PAD_IN_BIT      = 2;
  localparam int          STAT_RISE_BIT        = 3;
  localparam int          STAT_FALL_BIT        = 4;
  localparam int          STAT_PAD_OUT_BIT     = 5;
  localparam int          STAT_OE_BIT          = 6;

  // Output register modes
  localparam logic [1:0]  OMODE_SDR_FF         = 2'h0;
  localparam logic [1:0]  OMODE_SDR_LATCH      = 2'h1;
  localparam logic [1:0]  OMODE_DDR_GENERIC    = 2'h2;
  localparam logic [1:0]  OMODE_DDR_MEMORY     = 2'h3;

  // Cell location on the die
  localparam logic [1:0]  EDGE_LEFT            = 2'h0;
  localparam logic [1:0]  EDGE_TOP             = 2'h1;
  localparam logic [1:0]  EDGE_BOTTOM          = 2'h2;
  localparam logic [1:0]  EDGE_RIGHT           = 2'h3;

  // Delay elements, counted in ref_clk cycles
  localparam int          DLY_LINE_LEN         = 32;
  localparam logic [4:0]  FIXED_DLY_TAPS       = 5'h04;

  // Values forced by the local set/reset
  localparam logic        DATA_SR_VALUE        = 1'b0;
  localparam logic        TS_SR_VALUE          = 1'b1;

endpackage : iocell_pkg

// ---- iocell_delay_line.sv ----
module iocell_delay_line
  import iocell_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       din,
  input  wire logic       fixed_en,
  input  wire logic       dyn_en,
  input  wire logic [4:0] dyn_sel,
  output logic            dout
);

  logic [DLY_LINE_LEN-1:0] line_ff;
  logic [DLY_LINE_LEN-1:0] nxt_line;
  logic                    dout_ff;
  logic [4:0]              fixed_tap;
  logic [4:0]              total_tap;
  logic                    any_dly;
  logic                    nxt_dout;

  // Tap choice: fixed delay, dynamic delay, or both summed and saturated
  assign fixed_tap = fixed_en ? FIXED_DLY_TAPS : 5'h00;
  assign total_tap = (dyn_en && (6'(dyn_sel) + 6'(fixed_tap) > 6'(DLY_LINE_LEN - 1))) ? 5'(DLY_LINE_LEN - 1)
                   : (dyn_en ? 5'(dyn_sel + fixed_tap) : fixed_tap);
  assign any_dly   = fixed_en || dyn_en;
  assign nxt_line  = {line_ff[DLY_LINE_LEN-2:0], din};
  assign nxt_dout  = any_dly ? line_ff[total_tap] : din;
  assign dout      = dout_ff;

  // Shift line and registered tap output
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      line_ff <= '0;
      dout_ff <= 1'b0;
    end else begin
      line_ff <= nxt_line;
      dout_ff <= nxt_dout;
    end
  end

endmodule : iocell_delay_line

// ---- iocell_far_model.sv ----
module iocell_far_model #(
  parameter int HALF = 12
)(
  input  wire logic ref_clk,
  input  wire logic swap_pol,
  output logic      sys_clk_in,
  output logic      strobe_read_clk_shifted,
  output logic      strobe_write_clk_shifted,
  output logic      ddr_capture_polarity
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] phase_ff = 8'h00;

  // Free running system clock, four quarters of HALF cycles each
  always_ff @(posedge ref_clk) begin
    phase_ff <= (phase_ff == 8'(4 * HALF - 1)) ? 8'h00 : phase_ff + 8'h01;
  end

  // Strobes lag the system clock by one quarter period
  assign sys_clk_in               = (phase_ff < 8'(2 * HALF));
  assign strobe_read_clk_shifted  = (phase_ff >= 8'(HALF)) && (phase_ff < 8'(3 * HALF));
  assign strobe_write_clk_shifted = strobe_read_clk_shifted;
  assign ddr_capture_polarity     = swap_pol;
endmodule : iocell_far_model

// ---- iocell_top_props.sv ----
module iocell_top_props
  import iocell_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       pad_in,
  input wire logic       cell_clk_en,
  input wire logic       local_sr,
  input wire logic       bypass_comb_in,
  input wire logic       bypass_clock_in,
  input wire logic       pad_out,
  input wire logic       pad_output_enable,
  input wire logic       pad_pull_up,
  input wire logic       pad_pull_down
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Bus setup cycle and a run of held cell storage
  sequence s_setup; psel && !penable; endsequence
  sequence s_held; (!cell_clk_en && !local_sr) [*3]; endsequence

  property p_pready_after_setup; s_setup |=> pready; endproperty
  a_pready_after_setup: assert property (p_pready_after_setup) else $error("no pready after setup");
  property p_pready_single; pready |=> !pready; endproperty
  a_pready_single: assert property (p_pready_single) else $error("pready longer than one cycle");
  property p_slverr_unmapped;
    s_setup ##0 (paddr != IOCELL_CTRL_ADDR && paddr != IOCELL_STATUS_ADDR) |=> pready && pslverr;
  endproperty
  a_slverr_unmapped: assert property (p_slverr_unmapped) else $error("unmapped access not refused");
  property p_bypass_follow; bypass_comb_in |-> $past(pad_in, 3); endproperty
  a_bypass_follow: assert property (p_bypass_follow) else $error("bypass not from pad");
  property p_bypass_pair; bypass_comb_in == bypass_clock_in; endproperty
  a_bypass_pair: assert property (p_bypass_pair) else $error("bypass outputs differ");
  property p_sr_release; local_sr [*2] |=> !pad_output_enable; endproperty
  a_sr_release: assert property (p_sr_release) else $error("set reset left pad driven");
  property p_blank_quiet; (pad_pull_up || pad_pull_down) |-> !pad_output_enable && !pad_out; endproperty
  a_blank_quiet: assert property (p_blank_quiet) else $error("blank pad driven");
  property p_pull_exclusive; !(pad_pull_up && pad_pull_down); endproperty
  a_pull_exclusive: assert property (p_pull_exclusive) else $error("both pulls on");
  property p_hold_oe; s_held |-> $stable(pad_output_enable); endproperty
  a_hold_oe: assert property (p_hold_oe) else $error("enable moved while held");
endmodule : iocell_top_props

bind iocell_top iocell_top_props i_props (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .pad_in(pad_in), .cell_clk_en(cell_clk_en), .local_sr(local_sr),
  .bypass_comb_in(bypass_comb_in), .bypass_clock_in(bypass_clock_in), .pad_out(pad_out),
  .pad_output_enable(pad_output_enable), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down)
);

// ---- iocell_top_tb.sv ----
module iocell_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iocell_pkg::*;
  logic        ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic        pad_in = 1'b0, por_released = 1'b0, cell_clk_en = 1'b1, local_sr = 1'b0, swap_pol = 1'b0;
  logic        core_out_first = 1'b0, core_out_second = 1'b0, core_tristate_ctl = 1'b1, e;
  logic [4:0]  dynamic_delay_sel = 5'h00;
  logic        pready, pslverr, bypass_comb_in, bypass_clock_in, in_rise_sample, in_fall_or_sdr_sample;
  logic        pad_out, pad_output_enable, pad_pull_up, pad_pull_down, sys_clk_in, ddr_capture_polarity;
  logic        strobe_read_clk_shifted, strobe_write_clk_shifted;
  logic [15:0] lfsr = 16'h1775;
  int          errors = 0, n_compared = 0;

  // Clock
  always #5 ref_clk = ~ref_clk;

  iocell_far_model i_far (.ref_clk(ref_clk), .swap_pol(swap_pol), .sys_clk_in(sys_clk_in),
    .strobe_read_clk_shifted(strobe_read_clk_shifted), .strobe_write_clk_shifted(strobe_write_clk_shifted),
    .ddr_capture_polarity(ddr_capture_polarity));

  iocell_top #(.CELL_EDGE(EDGE_RIGHT), .PROG_PIN(1'b0)) i_dut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .sys_clk_in(sys_clk_in), .strobe_read_clk_shifted(strobe_read_clk_shifted),
    .strobe_write_clk_shifted(strobe_write_clk_shifted), .ddr_capture_polarity(ddr_capture_polarity),
    .por_released(por_released), .cell_clk_en(cell_clk_en), .local_sr(local_sr),
    .dynamic_delay_sel(dynamic_delay_sel), .core_out_first(core_out_first), .core_out_second(core_out_second),
    .core_tristate_ctl(core_tristate_ctl), .bypass_comb_in(bypass_comb_in), .bypass_clock_in(bypass_clock_in),
    .in_rise_sample(in_rise_sample), .in_fall_or_sdr_sample(in_fall_or_sdr_sample), .pad_out(pad_out),
    .pad_output_enable(pad_output_enable), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down));

  // Verdict
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer, entered just after an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    chk(n < 16, 1, "pready wait");
  endtask : apb

  task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic ex);
    apb(1'b0, a, 32'h0000_0000);
    chk(r & m, x, "read data");
    chk(e, ex, "slverr");
  endtask : rd_chk

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  function logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function logic exp_rise(input logic [31:0] c, input logic v);
    return c[CTRL_IN_DDR_BIT] ? v : 1'b0;
  endfunction : exp_rise

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    final_report;
  end

  // Main sequence
  initial begin : main
    logic [31:0] c;
    int          agr_sys, agr_wr;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(pad_pull_down, 1, "blank pull");
    chk(pad_pull_up, 0, "blank pull up");
    chk(pad_output_enable, 0, "blank enable");
    apb(1'b1, IOCELL_CTRL_ADDR, 32'h0000_0100);
    rd_chk(IOCELL_CTRL_ADDR, 32'hFFFF_FFFF, 32'h0000_0100, 1'b0);
    cyc(10);
    chk(pad_pull_down, 1, "pull before power release");
    por_released <= 1'b1;
    cyc(10);
    chk(pad_pull_down, 0, "pull after configuration");
    rd_chk(IOCELL_STATUS_ADDR, 32'h0000_0001, 32'h0000_0001, 1'b0);
    rd_chk(8'h08, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    // Random modes of input, output and enable paths
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      c = {23'h0, 1'b1, 1'b0, k[1:0], (k == 7), k[2], lfsr[4], lfsr[3], 1'b0};
      apb(1'b1, IOCELL_CTRL_ADDR, c);
      rd_chk(IOCELL_CTRL_ADDR, 32'hFFFF_FFFF, c, 1'b0);
      pad_in <= lfsr[0];
      core_out_first <= lfsr[1];
      core_out_second <= lfsr[1];
      core_tristate_ctl <= lfsr[2];
      dynamic_delay_sel <= lfsr[9:5];
      swap_pol <= lfsr[6];
      cyc(120);
      chk(in_rise_sample, exp_rise(c, lfsr[0]), "rise sample");
      chk(in_fall_or_sdr_sample, lfsr[0], "fall or sdr sample");
      chk(pad_out, lfsr[1], "pad out");
      chk(pad_output_enable, !lfsr[2], "pad enable");
    end
    // Output mux phase: generic follows system clock, memory follows write strobe
    core_out_first <= 1'b1;
    core_out_second <= 1'b0;
    for (int m = 2; m < 4; m++) begin
      apb(1'b1, IOCELL_CTRL_ADDR, 32'h0000_0100 | (m << CTRL_OMODE_LSB));
      cyc(60);
      agr_sys = 0;
      agr_wr = 0;
      repeat (96) begin
        @(posedge ref_clk);
        agr_sys += (pad_out === sys_clk_in);
        agr_wr += (pad_out === strobe_write_clk_shifted);
      end
      chk((m == 2) ? (agr_sys > agr_wr) : (agr_wr > agr_sys), 1, "mux phase");
    end
    // Clock enable low holds output and enable
    apb(1'b1, IOCELL_CTRL_ADDR, 32'h0000_0100);
    core_tristate_ctl <= 1'b0;
    cyc(100);
    cell_clk_en <= 1'b0;
    core_out_first <= 1'b0;
    core_tristate_ctl <= 1'b1;
    cyc(100);
    chk(pad_out, 1, "held pad");
    chk(pad_output_enable, 1, "held enable");
    cell_clk_en <= 1'b1;
    cyc(100);
    chk(pad_out, 0, "released pad");
    // Local set reset with live data
    core_out_first <= 1'b1;
    core_tristate_ctl <= 1'b0;
    pad_in <= 1'b1;
    cyc(100);
    local_sr <= 1'b1;
    cyc(10);
    chk(pad_out, 0, "sr pad");
    chk(pad_output_enable, 0, "sr enable");
    chk(in_fall_or_sdr_sample, 0, "sr sample");
    local_sr <= 1'b0;
    cyc(100);
    chk(pad_out, 1, "after sr");
    // Bypass follows the pad
    apb(1'b1, IOCELL_CTRL_ADDR, 32'h0000_0101);
    for (int i = 0; i < 6; i++) begin
      pad_in <= i[0];
      cyc(8);
      chk(bypass_comb_in, i[0], "bypass comb");
      chk(bypass_clock_in, i[0], "bypass clock");
    end
    final_report;
  end
endmodule : iocell_top_tb
